/* pkg/rms_pkg.sv */
// constants, types and functions for the rod move sequencer
// Overview of operation
// R1: momentary rod-in gives timed insert pulse
// R2: settle bus leads and outlasts insert drop
// R3: insert interval sized for one notch
// R4: held rod-in keeps inserting continuously
// R5: emergency-in holds insert bus on
// R6: withdraw starts with short unlatch insert
// R7: then withdraw and settle buses timed
// R8: withdraw drops first; settle end completes
// R9: withdraw runs same if switch released
// R10: withdraw intervals sized for one notch
// R11: timer failure drops all drive buses
// R12: rod-out plus notch-override withdraws continuously
// R13: stabilizing valves follow insert/withdraw buses
// R14: two block channels, either inhibits withdraw
// R15: block mid-withdraw stops at next notch
// R16: refuel trips feed both block channels
// R17: shutdown mode blocks all withdrawal
// R18: power/local monitor upscale or inop blocks
// R19: discharge volume high or bypassed blocks
// R20: minimizer insert and withdraw blocks honoured
// R21: position fault or timer fault blocks
// R22: run mode adds unbypassed downscale blocks
// R23: one rod selected, locked while moving
// R24: insert bus opens both selected insert valves
// R25: withdraw plus settle open both withdraw valves
// R26: settle phase opens only settle valve
// R27: all intervals are configurable cycle counts
package rms_pkg;
  localparam int CW = 16;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_INS = 8'h08;
  localparam logic [7:0] ADDR_LEAD = 8'h0c;
  localparam logic [7:0] ADDR_UNL = 8'h10;
  localparam logic [7:0] ADDR_WDR = 8'h14;
  localparam logic [7:0] ADDR_SET = 8'h18;
  localparam logic [7:0] ADDR_TFCNT = 8'h1c;
  localparam logic CTRL_RST = 1'b1;
  // trip vector bit positions, same layout in both channels
  localparam int T_APM_UP = 0;
  localparam int T_APM_INOP = 1;
  localparam int T_LBM_UP = 2;
  localparam int T_LBM_INOP = 3;
  localparam int T_SDV_HIGH = 4;
  localparam int T_SDV_BYP = 5;
  localparam int T_WM_WDR = 6;
  localparam int T_POS_FAIL = 7;
  localparam int T_TMR_FAIL = 8;
  localparam int T_APM_DOWN = 9;
  localparam int T_LBM_DOWN = 10;
  localparam int T_REFUEL = 11;
  localparam int NTRIP = 12;
  typedef enum logic [1:0] {
    MODE_SHUTDOWN = 2'h0,
    MODE_REFUEL = 2'h1,
    MODE_STARTUP = 2'h2,
    MODE_RUN = 2'h3
  } rms_mode_t;
  // gray along insert path except the ST_INS to ST_SETTLE block exit, and within the withdraw phases (ST_W_UNL to ST_W_SET)
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_INS = 3'h1,
    ST_INS_SET = 3'h3,
    ST_SETTLE = 3'h2,
    ST_W_UNL = 3'h6,
    ST_W_DRV = 3'h7,
    ST_W_SET = 3'h5,
    ST_FAULT = 3'h4
  } rms_state_t;
  typedef struct packed {
    logic ins;
    logic wdr;
    logic settle;
  } rms_bus_t;

  // one block channel
  function automatic logic rms_chan_block(input logic [NTRIP-1:0] t, input rms_mode_t m);
    logic b;
    // R18 monitor alarms
    b = t[T_APM_UP] | t[T_APM_INOP] | t[T_LBM_UP] | t[T_LBM_INOP];
    // R19 discharge volume
    b = b | t[T_SDV_HIGH] | t[T_SDV_BYP];
    // R20 minimizer withdraw block
    b = b | t[T_WM_WDR];
    // R21 position and timer faults
    b = b | t[T_POS_FAIL] | t[T_TMR_FAIL];
    // R16 refuel trips joined
    b = b | t[T_REFUEL];
    // R22 run downscale alarms
    if (m == MODE_RUN) begin
      b = b | t[T_APM_DOWN] | t[T_LBM_DOWN];
    end
    // R17 shutdown mode blocks
    if (m == MODE_SHUTDOWN) begin
      b = 1'b1;
    end
    return b;
  endfunction : rms_chan_block

  // bus pattern per state
  function automatic rms_bus_t rms_bus_of(input rms_state_t s);
    rms_bus_t r;
    r = '0;
    case (s)
      // R1 insert pulse
      ST_INS: r.ins = 1'b1;
      // R2 settle overlap
      ST_INS_SET: begin
        r.ins = 1'b1;
        r.settle = 1'b1;
      end
      // R6 unlatch pulse
      ST_W_UNL: r.ins = 1'b1;
      // R7 withdraw with settle
      ST_W_DRV: begin
        r.wdr = 1'b1;
        r.settle = 1'b1;
      end
      // R26 settle only
      ST_SETTLE, ST_W_SET: r.settle = 1'b1;
      default: r = '0;
    endcase
    return r;
  endfunction : rms_bus_of
endpackage : rms_pkg

/* pkg/rms_tmr_if.sv */
// interval timer carrier between sequencer and timer
`timescale 1ns/1ps
interface rms_tmr_if #(parameter int W = 16);
  logic start;
  logic [W-1:0] len;
  logic expire;
  logic fault;
  modport ctl (output start, output len, input expire, input fault);
  modport tmr (input start, input len, output expire, output fault);
endinterface : rms_tmr_if

/* rtl/rms_interval_timer.sv */
// one-shot interval timer with zero-length fault
`timescale 1ns/1ps
module rms_interval_timer #(parameter int W = 16) (
  input wire logic clock_i,
  input wire logic rst_i,
  rms_tmr_if.tmr t
);
  logic [W-1:0] cnt_q;
  logic busy_q;
  logic exp_q;
  logic flt_q;

  assign t.expire = exp_q;
  assign t.fault = flt_q;

  // expire pulses one cycle after the count reaches one
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
      exp_q <= 1'b0;
    end else if (t.start) begin
      cnt_q <= t.len;
      busy_q <= (t.len != '0);
      exp_q <= 1'b0;
    end else if (busy_q) begin
      cnt_q <= cnt_q - 1'b1;
      busy_q <= (cnt_q > W'(1));
      exp_q <= (cnt_q == W'(1));
    end else begin
      exp_q <= 1'b0;
    end
  end

  // a zero interval would never end: report it as failed
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      flt_q <= 1'b0;
    end else begin
      flt_q <= t.start && (t.len == '0);
    end
  end
endmodule : rms_interval_timer

/* rtl/rms_sequencer.sv */
// rod move sequencer, block logic and apb registers
`timescale 1ns/1ps
module rms_sequencer #(
  parameter int NROD = 16,
  parameter int SW = 4,
  parameter logic [15:0] INS_CYC = 16'h0fa0,
  parameter logic [15:0] LEAD_CYC = 16'h0190,
  parameter logic [15:0] UNL_CYC = 16'h0320,
  parameter logic [15:0] WDR_CYC = 16'h0fa0,
  parameter logic [15:0] SET_CYC = 16'h0c80
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic sel_req_i,
  input wire logic [SW-1:0] sel_idx_i,
  input wire logic rod_in_i,
  input wire logic rod_out_i,
  input wire logic emerg_in_i,
  input wire logic notch_ovr_i,
  input wire rms_pkg::rms_mode_t mode_i,
  input wire logic [rms_pkg::NTRIP-1:0] trip_a_i,
  input wire logic [rms_pkg::NTRIP-1:0] trip_b_i,
  input wire logic wm_ins_block_i,
  output logic ins_bus_o,
  output logic wdr_bus_o,
  output logic settle_bus_o,
  output logic stab_ins_o,
  output logic stab_wdr_o,
  output logic [2*NROD-1:0] ins_valve_o,
  output logic [NROD-1:0] wdr_valve_o,
  output logic [NROD-1:0] settle_valve_o,
  output logic block_a_o,
  output logic block_b_o,
  output logic sel_valid_o,
  output logic [SW-1:0] sel_idx_o
);
  import rms_pkg::*;

  rms_tmr_if #(.W(CW)) tif ();

  rms_interval_timer #(.W(CW)) u_tmr (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .t(tif)
  );

  rms_state_t state_q;
  rms_state_t state_d;
  logic reload;
  logic out_q;
  logic en_q;
  logic [CW-1:0] ins_q;
  logic [CW-1:0] lead_q;
  logic [CW-1:0] unl_q;
  logic [CW-1:0] wdr_q;
  logic [CW-1:0] set_q;
  logic [CW-1:0] tfcnt_q;
  logic sel_valid_q;
  logic [SW-1:0] sel_q;
  logic blk_a;
  logic blk_b;
  logic wdr_blk;
  logic ins_req;
  logic out_press;
  logic cont_wdr;
  logic moving;
  rms_bus_t bus_d;
  logic acc;
  logic wr_acc;
  logic [31:0] rdata;
  logic hit;

  // R14 two channels
  assign blk_a = rms_chan_block(trip_a_i, mode_i);
  assign blk_b = rms_chan_block(trip_b_i, mode_i);
  // R14 either channel inhibits
  assign wdr_blk = blk_a | blk_b;
  assign ins_req = rod_in_i | emerg_in_i;
  assign out_press = rod_out_i & ~out_q;
  // R12 continuous withdraw
  assign cont_wdr = rod_out_i & notch_ovr_i;
  assign moving = (state_q != ST_IDLE);

  // edge memory so a held rod-out without notch override gives only one notch
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      out_q <= 1'b0;
    end else begin
      out_q <= rod_out_i;
    end
  end

  // R23 selection lock
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sel_valid_q <= 1'b0;
      sel_q <= '0;
    end else if (sel_req_i && !moving && state_d == ST_IDLE) begin
      sel_valid_q <= 1'b1;
      sel_q <= sel_idx_i;
    end
  end

  always_comb begin
    state_d = state_q;
    reload = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (en_q && sel_valid_q && ins_req && !wm_ins_block_i) begin
          state_d = ST_INS;
        end else if (en_q && sel_valid_q && out_press && !wdr_blk) begin
          state_d = ST_W_UNL;
        end
      end
      ST_INS: begin
        // R20 insert block
        if (wm_ins_block_i) begin
          state_d = ST_SETTLE;
        // R4 R5 held switch restarts interval
        end else if (ins_req) begin
          reload = 1'b1;
        // R3 notch interval end
        end else if (tif.expire) begin
          state_d = ST_INS_SET;
        end
      end
      ST_INS_SET: begin
        // R2 settle outlasts insert
        if (tif.expire || wm_ins_block_i) begin
          state_d = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (tif.expire) begin
          state_d = ST_IDLE;
        end
      end
      ST_W_UNL: begin
        // R7 withdraw after unlatch
        if (tif.expire) begin
          state_d = ST_W_DRV;
        end
      end
      ST_W_DRV: begin
        // R9 R10 notch ends on timer only
        if (tif.expire) begin
          // R15 block ends at notch
          if (cont_wdr && !wdr_blk) begin
            reload = 1'b1;
          end else begin
            // R8 withdraw drops first
            state_d = ST_W_SET;
          end
        end
      end
      ST_W_SET: begin
        // R8 settle end completes
        if (tif.expire) begin
          state_d = ST_IDLE;
        end
      end
      ST_FAULT: begin
        if (!ins_req && !rod_out_i && !notch_ovr_i) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_FAULT;
    endcase
    // R11 timer failure stops drive
    if (tif.fault) begin
      state_d = ST_FAULT;
      reload = 1'b0;
    end
  end

  // start the timer on every phase entry or reload
  always_comb begin
    tif.start = reload || (state_d != state_q);
    case (state_d)
      // R27 configurable counts
      ST_INS: tif.len = ins_q - lead_q;
      ST_INS_SET: tif.len = lead_q;
      ST_W_UNL: tif.len = unl_q;
      ST_W_DRV: tif.len = wdr_q;
      ST_SETTLE, ST_W_SET: tif.len = set_q;
      default: tif.len = CW'(1);
    endcase
    if (state_d == ST_IDLE || state_d == ST_FAULT) begin
      tif.start = 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_comb begin
    bus_d = rms_bus_of(state_d);
    // R11 zero interval drives nothing
    if (tif.start && tif.len == '0) begin
      bus_d = '0;
    end
  end

  // outputs registered from next state so they align with it
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ins_bus_o <= 1'b0;
      wdr_bus_o <= 1'b0;
      settle_bus_o <= 1'b0;
      stab_ins_o <= 1'b0;
      stab_wdr_o <= 1'b0;
    end else begin
      ins_bus_o <= bus_d.ins;
      wdr_bus_o <= bus_d.wdr;
      settle_bus_o <= bus_d.settle;
      // R13 stabilizing valves follow
      stab_ins_o <= bus_d.ins;
      stab_wdr_o <= bus_d.wdr;
    end
  end

  // valves only on the selected rod
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ins_valve_o <= '0;
      wdr_valve_o <= '0;
      settle_valve_o <= '0;
    end else begin
      ins_valve_o <= '0;
      wdr_valve_o <= '0;
      settle_valve_o <= '0;
      if (sel_valid_q) begin
        // R24 both insert valves
        ins_valve_o[2*sel_q] <= bus_d.ins;
        ins_valve_o[2*sel_q+1] <= bus_d.ins;
        // R25 withdraw needs both buses
        wdr_valve_o[sel_q] <= bus_d.wdr & bus_d.settle;
        // R26 settle valve alone
        settle_valve_o[sel_q] <= bus_d.settle;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      block_a_o <= 1'b0;
      block_b_o <= 1'b0;
      sel_valid_o <= 1'b0;
      sel_idx_o <= '0;
    end else begin
      block_a_o <= blk_a;
      block_b_o <= blk_b;
      sel_valid_o <= sel_valid_q;
      sel_idx_o <= sel_q;
    end
  end

  // timer failures seen since reset, saturating
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      tfcnt_q <= '0;
    end else if (tif.fault && tfcnt_q != '1) begin
      tfcnt_q <= tfcnt_q + 1'b1;
    end
  end

  // apb: pready rises one cycle into the access phase
  assign acc = psel_i && penable_i && pready_o;
  assign wr_acc = acc && pwrite_i;

  always_comb begin
    rdata = '0;
    hit = 1'b1;
    case (paddr_i)
      ADDR_CTRL: rdata[0] = en_q;
      ADDR_STATUS: rdata = {{(32-9-SW){1'b0}}, sel_q, sel_valid_q, blk_b, blk_a,
                            settle_bus_o, wdr_bus_o, ins_bus_o, 3'(state_q)};
      ADDR_INS: rdata[CW-1:0] = ins_q;
      ADDR_LEAD: rdata[CW-1:0] = lead_q;
      ADDR_UNL: rdata[CW-1:0] = unl_q;
      ADDR_WDR: rdata[CW-1:0] = wdr_q;
      ADDR_SET: rdata[CW-1:0] = set_q;
      ADDR_TFCNT: rdata[CW-1:0] = tfcnt_q;
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pready_o <= 1'b0;
      prdata_o <= '0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i && penable_i && !pready_o;
      pslverr_o <= psel_i && penable_i && !pready_o && !hit;
      if (psel_i && penable_i && !pready_o && !pwrite_i) begin
        prdata_o <= rdata;
      end
    end
  end

  // timing writes take effect at once; changing them mid-cycle
  // alters only phases not yet started
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      en_q <= CTRL_RST;
      ins_q <= INS_CYC;
      lead_q <= LEAD_CYC;
      unl_q <= UNL_CYC;
      wdr_q <= WDR_CYC;
      set_q <= SET_CYC;
    end else if (wr_acc) begin
      case (paddr_i)
        ADDR_CTRL: en_q <= pwdata_i[0];
        ADDR_INS: ins_q <= pwdata_i[CW-1:0];
        ADDR_LEAD: lead_q <= pwdata_i[CW-1:0];
        ADDR_UNL: unl_q <= pwdata_i[CW-1:0];
        ADDR_WDR: wdr_q <= pwdata_i[CW-1:0];
        ADDR_SET: set_q <= pwdata_i[CW-1:0];
        default: en_q <= en_q;
      endcase
    end
  end
endmodule : rms_sequencer

/* tb/rms_chk.sv */
// concurrent checks on the rod move sequencer ports
`timescale 1ns/1ps
module rms_chk #(
  parameter int NROD = 16,
  parameter int SW = 4,
  parameter logic [15:0] LEAD_CYC = 16'h0190,
  parameter logic [15:0] UNL_CYC = 16'h0320,
  parameter logic [15:0] SET_CYC = 16'h0c80
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire rms_pkg::rms_mode_t mode_i,
  input wire logic [rms_pkg::NTRIP-1:0] trip_a_i,
  input wire logic ins_bus_o,
  input wire logic wdr_bus_o,
  input wire logic settle_bus_o,
  input wire logic stab_ins_o,
  input wire logic stab_wdr_o,
  input wire logic [2*NROD-1:0] ins_valve_o,
  input wire logic [NROD-1:0] wdr_valve_o,
  input wire logic [NROD-1:0] settle_valve_o,
  input wire logic block_a_o,
  input wire logic block_b_o,
  input wire logic [SW-1:0] sel_idx_o
);
  import rms_pkg::*;
  logic [16:0] ins_run_q;
  logic [16:0] ovl_run_q;
  logic [16:0] set_run_q;
  // phase lengths, counted as runs of bus patterns
  always_ff @(posedge clock_i) begin
    ins_run_q <= (rst_i || !ins_bus_o) ? '0 : ins_run_q + 17'h1;
    ovl_run_q <= (rst_i || !(ins_bus_o && settle_bus_o)) ? '0 : ovl_run_q + 17'h1;
    set_run_q <= (rst_i || !settle_bus_o || ins_bus_o || wdr_bus_o) ? '0 : set_run_q + 17'h1;
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  a_stab_follow: assert property (stab_ins_o == ins_bus_o && stab_wdr_o == wdr_bus_o)
    else $error("stabilizer differs from bus");
  a_wdr_settle: assert property (wdr_bus_o |-> settle_bus_o && !ins_bus_o)
    else $error("withdraw bus without settle");
  a_unlatch_len: assert property ($rose(wdr_bus_o) |-> $past(ins_bus_o)
    && ins_run_q == {1'b0, UNL_CYC} + 17'h1)
    else $error("unlatch pulse length wrong");
  a_settle_len: assert property ($fell(settle_bus_o) |-> set_run_q == {1'b0, SET_CYC} + 17'h1)
    else $error("settle tail length wrong");
  a_lead_len: assert property ($fell(ins_bus_o) && settle_bus_o && !wdr_bus_o
    |-> ovl_run_q == {1'b0, LEAD_CYC} + 17'h1)
    else $error("settle lead length wrong");
  a_ins_valves: assert property ($countones(ins_valve_o) == (ins_bus_o ? 2 : 0))
    else $error("insert valve count wrong");
  a_settle_only: assert property ((!settle_bus_o || settle_valve_o[sel_idx_o])
    && $countones(wdr_valve_o) == (wdr_bus_o ? 1 : 0))
    else $error("valve pattern wrong");
  a_shut_block: assert property (mode_i == MODE_SHUTDOWN |=> block_a_o && block_b_o)
    else $error("shutdown without block");
  a_chan_trip: assert property (|(trip_a_i & 12'h9ff) |=> block_a_o)
    else $error("channel trip without block");
  a_sel_lock: assert property (ins_bus_o || settle_bus_o |=> $stable(sel_idx_o))
    else $error("selection moved mid cycle");
endmodule : rms_chk

bind rms_sequencer rms_chk #(.NROD(NROD), .SW(SW), .LEAD_CYC(LEAD_CYC), .UNL_CYC(UNL_CYC),
  .SET_CYC(SET_CYC)) u_chk (.clock_i, .rst_i, .mode_i, .trip_a_i, .ins_bus_o, .wdr_bus_o,
  .settle_bus_o, .stab_ins_o, .stab_wdr_o, .ins_valve_o, .wdr_valve_o, .settle_valve_o,
  .block_a_o, .block_b_o, .sel_idx_o);

/* tb/rms_rod_model.sv */
// rod drive model: counts finished notches from valve drive
`timescale 1ns/1ps
module rms_rod_model #(
  parameter int NROD = 16
) (
  input wire logic clock_i,
  input wire logic [2*NROD-1:0] ins_valve_i,
  input wire logic [NROD-1:0] wdr_valve_i,
  input wire logic [NROD-1:0] settle_valve_i,
  output int notch_out_o,
  output int notch_in_o
);
  logic out_q = 0;
  logic in_q = 0;
  logic set_q = 0;
  always @(posedge clock_i) begin
    // both withdraw valves move rod out
    if (|(wdr_valve_i & settle_valve_i)) out_q = 1;
    // insert valve pair moves rod in
    if (|ins_valve_i) in_q = 1;
    if (set_q && !(|settle_valve_i)) begin
      if (out_q) notch_out_o++;
      else if (in_q) notch_in_o++;
      out_q = 0;
      in_q = 0;
    end
    set_q = |settle_valve_i;
  end
endmodule : rms_rod_model

/* tb/rms_sequencer_tb.sv */
// self-checking bench for the rod move sequencer
`timescale 1ns/1ps
`define CHK(x, y) begin \
  n_tests++; \
  if ((x) !== (y)) begin \
    num_errors++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, (x), (y)); \
  end \
end
module rms_sequencer_tb;
  import rms_pkg::*;
  // short intervals keep the run brief
  localparam int INS = 10, LEAD = 3, UNL = 4, WDR = 10, SET = 6;
  int num_errors = 0;
  int n_tests = 0;
  int n_out, n_in, ni, nw, ns, no;
  logic clock_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, e;
  logic sel_req_i = 0, rod_in_i = 0, rod_out_i = 0, emerg_in_i = 0, notch_ovr_i = 0;
  logic wm_ins_block_i = 0, pready_o, pslverr_o, ins_bus_o, wdr_bus_o, settle_bus_o;
  logic stab_ins_o, stab_wdr_o, block_a_o, block_b_o, sel_valid_o;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd, ins_valve_o;
  logic [3:0] sel_idx_i = 4'h5, sel_idx_o;
  logic [15:0] wdr_valve_o, settle_valve_o;
  logic [11:0] trip_a_i = 12'h000, trip_b_i = 12'h000;
  rms_mode_t mode_i = MODE_RUN;
  initial forever #12.5 clock_i = ~clock_i;
  rms_sequencer #(.INS_CYC(16'(INS)), .LEAD_CYC(16'(LEAD)), .UNL_CYC(16'(UNL)),
    .WDR_CYC(16'(WDR)), .SET_CYC(16'(SET))) uut (.clock_i, .rst_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .sel_req_i, .sel_idx_i,
    .rod_in_i, .rod_out_i, .emerg_in_i, .notch_ovr_i, .mode_i, .trip_a_i, .trip_b_i,
    .wm_ins_block_i, .ins_bus_o, .wdr_bus_o, .settle_bus_o, .stab_ins_o, .stab_wdr_o,
    .ins_valve_o, .wdr_valve_o, .settle_valve_o, .block_a_o, .block_b_o, .sel_valid_o,
    .sel_idx_o);
  rms_rod_model u_rod (.clock_i, .ins_valve_i(ins_valve_o), .wdr_valve_i(wdr_valve_o),
    .settle_valve_i(settle_valve_o), .notch_out_o(n_out), .notch_in_o(n_in));
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask : tick
  // request held until pready sampled high
  // no local limit: the watchdog ends a hung wait
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1;
    do begin
      @(posedge clock_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    e = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
    // idle edge so a following call never re-drives in this step
    @(posedge clock_i);
  endtask : apb
  // counts bus cycles of one movement
  task automatic watch(input int lim);
    int k;
    logic seen;
    ni = 0;
    nw = 0;
    ns = 0;
    no = 0;
    seen = 0;
    for (k = 0; k < lim; k++) begin
      @(posedge clock_i);
      if (ins_bus_o | wdr_bus_o | settle_bus_o) seen = 1;
      else if (seen) break;
      ni += ins_bus_o;
      nw += wdr_bus_o;
      ns += settle_bus_o;
      no += ins_bus_o & settle_bus_o;
    end
  endtask : watch
  task automatic s_regs();
    apb(0, ADDR_WDR, 0);
    `CHK(rd[15:0], 16'(WDR))
    apb(0, 8'h40, 0);
    `CHK({e, rd}, 33'h1_0000_0000)
  endtask : s_regs
  task automatic s_withdraw(input logic hold);
    int o;
    o = n_out;
    rod_out_i <= 1;
    tick(1);
    rod_out_i <= hold;
    watch(100);
    rod_out_i <= 0;
    tick(3);
    `CHK(ni, UNL + 1)
    `CHK(nw, WDR + 1)
    `CHK(ns, WDR + SET + 2)
    `CHK(n_out, o + 1)
    `CHK({ins_bus_o, wdr_bus_o}, 2'b00)
  endtask : s_withdraw
  task automatic s_insert();
    int i;
    i = n_in;
    rod_in_i <= 1;
    tick(1);
    rod_in_i <= 0;
    watch(100);
    tick(3);
    `CHK(no, LEAD + 1)
    `CHK(ns - no, SET + 1)
    `CHK((ni - no) inside {[INS - LEAD : INS - LEAD + 2]}, 1'b1)
    `CHK(n_in, i + 1)
  endtask : s_insert
  task automatic s_hold(input logic emerg);
    int c;
    c = 0;
    rod_in_i <= !emerg;
    emerg_in_i <= emerg;
    tick(2);
    repeat (30) begin
      @(posedge clock_i);
      c += ins_bus_o;
    end
    rod_in_i <= 0;
    emerg_in_i <= 0;
    if (emerg) `CHK(c, 30)
    else `CHK(c, 30)
    watch(100);
    // minimizer insert block outranks emergency-in
    wm_ins_block_i <= 1;
    emerg_in_i <= emerg;
    rod_in_i <= !emerg;
    tick(10);
    `CHK(ins_bus_o, 1'b0)
    wm_ins_block_i <= 0;
    emerg_in_i <= 0;
    rod_in_i <= 0;
    tick(15);
  endtask : s_hold
  task automatic s_trips();
    for (int i = 0; i < NTRIP; i++) begin
      trip_a_i <= 12'h001 << i;
      tick(2);
      `CHK({block_a_o, block_b_o}, 2'b10)
      trip_a_i <= 0;
      trip_b_i <= 12'h001 << i;
      tick(2);
      `CHK({block_a_o, block_b_o}, 2'b01)
      trip_b_i <= 0;
    end
    mode_i <= MODE_STARTUP;
    trip_a_i <= 12'h600;
    tick(2);
    `CHK(block_a_o, 1'b0)
    mode_i <= MODE_SHUTDOWN;
    trip_a_i <= 0;
    tick(2);
    `CHK({block_a_o, block_b_o}, 2'b11)
    rod_out_i <= 1;
    tick(1);
    rod_out_i <= 0;
    watch(15);
    `CHK(ni + nw, 0)
    mode_i <= MODE_RUN;
    tick(2);
  endtask : s_trips
  task automatic s_cont();
    rod_out_i <= 1;
    notch_ovr_i <= 1;
    tick(3 * WDR);
    `CHK(wdr_bus_o, 1'b1)
    trip_b_i <= 12'h001 << T_POS_FAIL;
    watch(100);
    rod_out_i <= 0;
    notch_ovr_i <= 0;
    trip_b_i <= 0;
    `CHK(nw > 0 && nw <= WDR + 2, 1'b1)
    `CHK(ns - nw, SET + 1)
  endtask : s_cont
  task automatic s_timer();
    apb(1, ADDR_WDR, 0);
    rod_out_i <= 1;
    tick(1);
    rod_out_i <= 0;
    watch(40);
    `CHK(nw + ns, 0)
    apb(0, ADDR_TFCNT, 0);
    `CHK(rd[15:0], 16'h0001)
    apb(1, ADDR_WDR, WDR);
    tick(2);
  endtask : s_timer
  task automatic s_select();
    rod_out_i <= 1;
    tick(1);
    rod_out_i <= 0;
    tick(3);
    sel_idx_i <= 4'h7;
    sel_req_i <= 1;
    tick(1);
    sel_req_i <= 0;
    watch(100);
    `CHK(sel_idx_o, 4'h5)
    sel_req_i <= 1;
    tick(2);
    sel_req_i <= 0;
    tick(1);
    `CHK(sel_idx_o, 4'h7)
  endtask : s_select
  task automatic conclude();
    $display("mismatches %0d of %0d comparisons", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  initial begin
    tick(10);
    rst_i <= 0;
    tick(1);
    `CHK({ins_bus_o, wdr_bus_o, settle_bus_o, sel_valid_o}, 4'h0)
    s_regs();
    sel_req_i <= 1;
    tick(1);
    sel_req_i <= 0;
    tick(2);
    `CHK({sel_valid_o, sel_idx_o}, 5'h15)
    s_withdraw(0);
    s_withdraw(1);
    s_insert();
    s_hold(0);
    s_hold(1);
    s_trips();
    s_cont();
    s_timer();
    s_select();
    conclude();
  end
  // watchdog well past the few hundred cycles needed
  initial begin
    tick(20000);
    num_errors++;
    conclude();
  end
endmodule : rms_sequencer_tb
